// [common/cps_pkg.sv]
`default_nettype none
package cps_pkg;
	// ------------------------------------------------------------
	// register indices, byte address is four times the index
	// ------------------------------------------------------------
	localparam int unsigned AW             = 20;
	localparam logic [15:0] IDX_VALID_HIGH = 16'hffd7;
	localparam logic [15:0] IDX_VALID_LOW  = 16'hffd8;
	localparam logic [15:0] IDX_DATA_HIGH  = 16'hffd9;
	localparam logic [15:0] IDX_DATA_LOW   = 16'hffda;
	localparam logic [15:0] IDX_CMD_ADDR   = 16'hffdb;
	localparam logic [15:0] IDX_CTRL       = 16'hffdc;
	localparam logic [15:0] IDX_STATUS     = 16'hffdd;
	// ------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  RST_BYTE       = 8'h00;
	localparam logic [6:0]  RST_CTRL       = 7'h00;
	localparam logic [7:0]  VALID_LOW_MASK = 8'hf8;
	localparam logic [7:0]  VALID_HIGH_SW  = 8'h9f;
	localparam int unsigned FRAME_TAG_BIT  = 7;
	localparam int unsigned PRI_READY_BIT  = 6;
	localparam int unsigned SEC_READY_BIT  = 5;
	localparam int unsigned CMD_RW_BIT     = 7;
	localparam int unsigned CTRL_START_BIT = 7;
	localparam int unsigned CTRL_ATTACH    = 2;
	localparam int unsigned SLOT_COUNT     = 10;
	localparam int unsigned FIFO_DEPTH     = 16;
	localparam int unsigned CMD_W          = 26;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	typedef enum logic [1:0] {
		CPS_MODE_GP    = 2'b00,
		CPS_MODE_8BIT  = 2'b01,
		CPS_MODE_AC97  = 2'b10,
		CPS_MODE_AC97B = 2'b11
	} cps_mode_e;
	typedef enum logic [2:0] {
		CPS_SEL_NONE   = 3'b000,
		CPS_SEL_VHIGH  = 3'b001,
		CPS_SEL_VLOW   = 3'b010,
		CPS_SEL_DHIGH  = 3'b011,
		CPS_SEL_DLOW   = 3'b100,
		CPS_SEL_ADDR   = 3'b101,
		CPS_SEL_CTRL   = 3'b110,
		CPS_SEL_STATUS = 3'b111
	} cps_sel_e;
endpackage : cps_pkg
`default_nettype wire

// [hdl/cps_codec_port.sv]
// Contract
// (RULE_01) on a write command, send the software data value to the chosen codec
// (RULE_02) on a read command, returned status data overwrites the data registers
// (RULE_03) data value is 16 bits, low byte and high byte registers
// (RULE_04) general-purpose and 8-bit codec modes exchange only the low byte
// (RULE_05) high data register unused in general-purpose and 8-bit codec modes
// (RULE_06) low valid-slot bits 7..3 tag slots 8..12, one means valid
// (RULE_07) high valid-slot bits 4..0 tag slots 3..7, one means valid
// (RULE_08) software clears valid bits of slots without valid data
// (RULE_09) high valid-slot bit 7 tags the frame as holding a valid slot
// (RULE_10) primary ready loaded each frame from primary slot 0 bit 15
// (RULE_11) secondary ready loaded each frame from secondary slot 0 bit 15
// (RULE_12) secondary ready ignored unless a secondary codec is attached
// (RULE_13) ready flags are read-only to software and reset to zero
// (RULE_14) valid-slot registers act only in the AC '97 modes
// (RULE_15) low valid-slot bits 2..0 read zero and ignore writes
// (RULE_16) data and valid-slot registers reset to zero
// (RULE_17) command address top bit selects read, low seven bits the address
// (RULE_18) codec id 00 selects primary, other values the secondary codec
// (RULE_19) data registers updated only after status fully received, never mid-write
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// command fifo
// ------------------------------------------------------------
module cps_fifo #(
	parameter int unsigned W = 8,
	parameter int unsigned D = 16
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int unsigned PW = $clog2(D);
	localparam int unsigned CW = $clog2(D + 1);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [PW-1:0]       wr;
		logic [PW-1:0]       rd;
		logic [CW-1:0]       count;
	} cps_fifo_s;
	cps_fifo_s s;
	cps_fifo_s next_s;
	logic      push;
	logic      pop;
	// honest full and empty straight from the count
	assign in_ready  = (s.count != CW'(D));
	assign out_valid = (s.count != '0);
	assign out_data  = s.mem[s.rd];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	always_comb begin
		next_s = s;
		if (push) begin
			next_s.mem[s.wr] = in_data;
			next_s.wr        = (s.wr == PW'(D - 1)) ? '0 : s.wr + PW'(1);
		end
		if (pop) begin
			next_s.rd = (s.rd == PW'(D - 1)) ? '0 : s.rd + PW'(1);
		end
		if (push && !pop) begin
			next_s.count = s.count + CW'(1);
		end else if (pop && !push) begin
			next_s.count = s.count - CW'(1);
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule : cps_fifo

// ------------------------------------------------------------
// register block and frame tagging
// ------------------------------------------------------------
module cps_codec_port (
	input  wire logic                 clk_sys,
	input  wire logic                 rst,
	input  wire logic [cps_pkg::AW-1:0] s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [cps_pkg::AW-1:0] s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic                 frame_start,
	input  wire logic                 primary_slot0_bit15,
	input  wire logic                 secondary_slot0_bit15,
	input  wire logic                 status_valid,
	input  wire logic [6:0]           status_addr,
	input  wire logic [15:0]          status_data,
	output logic                      cmd_valid,
	input  wire logic                 cmd_ready,
	output logic                      cmd_read,
	output logic                      cmd_secondary,
	output logic [7:0]                cmd_addr,
	output logic [15:0]               cmd_data,
	output logic [cps_pkg::SLOT_COUNT-1:0] slot_valid,
	output logic                      frame_valid_tag
);
	import cps_pkg::*;

	typedef struct packed {
		logic                  awready;
		logic                  wready;
		logic                  aw_held;
		logic [AW-1:0]         aw_q;
		logic                  w_held;
		logic [7:0]            w_q;
		logic                  w_lane0;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  arready;
		logic                  rvalid;
		logic [31:0]           rdata;
		logic [1:0]            rresp;
		logic [7:0]            slot_valid_high;
		logic [7:0]            slot_valid_low;
		logic [7:0]            cmd_data_high;
		logic [7:0]            cmd_data_low;
		logic [7:0]            cmd_address;
		logic [6:0]            ctrl;
		logic                  read_pending;
		logic                  cap_pending;
		logic [15:0]           cap_data;
		logic [6:0]            cap_addr;
		logic                  out_valid;
		logic [CMD_W-1:0]      out_word;
		logic [SLOT_COUNT-1:0] slots;
		logic                  frame_tag;
	} cps_state_s;

	cps_state_s       s;
	cps_state_s       next_s;
	logic             do_write;
	logic             data_wr;
	logic             apply;
	logic             fifo_in_ready;
	logic             fifo_out_valid;
	logic [CMD_W-1:0] fifo_out_data;
	logic             push;
	logic             pop;
	logic [CMD_W-1:0] push_word;
	cps_sel_e         wsel;
	cps_mode_e        mode;
	logic             ac97;

	function automatic cps_sel_e cps_decode(input logic [AW-1:0] a);
		logic [AW-3:0] idx;
		idx = a[AW-1:2];
		case (idx)
			(AW-2)'(IDX_VALID_HIGH): cps_decode = CPS_SEL_VHIGH;
			(AW-2)'(IDX_VALID_LOW):  cps_decode = CPS_SEL_VLOW;
			(AW-2)'(IDX_DATA_HIGH):  cps_decode = CPS_SEL_DHIGH;
			(AW-2)'(IDX_DATA_LOW):   cps_decode = CPS_SEL_DLOW;
			(AW-2)'(IDX_CMD_ADDR):   cps_decode = CPS_SEL_ADDR;
			(AW-2)'(IDX_CTRL):       cps_decode = CPS_SEL_CTRL;
			(AW-2)'(IDX_STATUS):     cps_decode = CPS_SEL_STATUS;
			default:                 cps_decode = CPS_SEL_NONE;
		endcase
	endfunction : cps_decode

	function automatic logic cps_is_ac97(input cps_mode_e m);
		cps_is_ac97 = (m == CPS_MODE_AC97) || (m == CPS_MODE_AC97B);
	endfunction : cps_is_ac97

	assign mode     = cps_mode_e'(s.ctrl[1:0]);
	assign ac97     = cps_is_ac97(mode);
	assign do_write = s.aw_held && s.w_held && !s.bvalid;
	assign wsel     = cps_decode(s.aw_q);
	assign data_wr  = do_write && s.w_lane0 &&
		(wsel == CPS_SEL_DHIGH || wsel == CPS_SEL_DLOW);
	// (RULE_19) defer capture past a write
	assign apply    = s.cap_pending && !data_wr;
	assign push     = do_write && s.w_lane0 && (wsel == CPS_SEL_CTRL) &&
		s.w_q[CTRL_START_BIT] && fifo_in_ready;
	assign pop      = fifo_out_valid && (!s.out_valid || cmd_ready);
	// (RULE_04) narrow modes send the low byte only
	// (RULE_18) nonzero id picks the secondary codec
	// (RULE_03) sixteen-bit data word
	assign push_word = {s.cmd_address[CMD_RW_BIT], (s.ctrl[4:3] != 2'b00),
		s.cmd_address, ac97 ? s.cmd_data_high : RST_BYTE, s.cmd_data_low};

	cps_fifo #(
		.W (CMD_W),
		.D (FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.in_data   (push_word),
		.out_valid (fifo_out_valid),
		.out_ready (!s.out_valid || cmd_ready),
		.out_data  (fifo_out_data)
	);

	always_comb begin
		next_s = s;
		// --------------------------------------------------------
		// axi write channels, taken in either order
		// --------------------------------------------------------
		if (s.awready && s_axi_awvalid) begin
			next_s.aw_held = 1'b1;
			next_s.aw_q    = s_axi_awaddr;
		end
		if (s.wready && s_axi_wvalid) begin
			next_s.w_held  = 1'b1;
			next_s.w_q     = s_axi_wdata[7:0];
			next_s.w_lane0 = s_axi_wstrb[0];
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		if (do_write) begin
			next_s.aw_held = 1'b0;
			next_s.w_held  = 1'b0;
			next_s.bvalid  = 1'b1;
			next_s.bresp   = (wsel == CPS_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			if (s.w_lane0) begin
				case (wsel)
					// (RULE_13) ready bits not writable
					CPS_SEL_VHIGH: next_s.slot_valid_high =
						(s.w_q & VALID_HIGH_SW) | (s.slot_valid_high & ~VALID_HIGH_SW);
					// (RULE_15) reserved bits stay zero
					CPS_SEL_VLOW:  next_s.slot_valid_low = s.w_q & VALID_LOW_MASK;
					CPS_SEL_DHIGH: next_s.cmd_data_high = s.w_q;
					CPS_SEL_DLOW:  next_s.cmd_data_low = s.w_q;
					CPS_SEL_ADDR:  next_s.cmd_address = s.w_q;
					CPS_SEL_CTRL:  next_s.ctrl = s.w_q[6:0];
					default: begin
					end
				endcase
			end
		end
		next_s.awready = !next_s.aw_held && !next_s.bvalid;
		next_s.wready  = !next_s.w_held && !next_s.bvalid;
		// --------------------------------------------------------
		// axi read channel, answer one cycle after the address
		// --------------------------------------------------------
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (s.arready && s_axi_arvalid) begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = RESP_OKAY;
			next_s.rdata  = '0;
			case (cps_decode(s_axi_araddr))
				CPS_SEL_VHIGH:  next_s.rdata[7:0] = s.slot_valid_high;
				CPS_SEL_VLOW:   next_s.rdata[7:0] = s.slot_valid_low;
				CPS_SEL_DHIGH:  next_s.rdata[7:0] = s.cmd_data_high;
				CPS_SEL_DLOW:   next_s.rdata[7:0] = s.cmd_data_low;
				CPS_SEL_ADDR:   next_s.rdata[7:0] = s.cmd_address;
				CPS_SEL_CTRL:   next_s.rdata[6:0] = s.ctrl;
				CPS_SEL_STATUS: next_s.rdata[2:0] =
					{!fifo_in_ready, s.cap_pending, s.read_pending};
				default:        next_s.rresp = RESP_SLVERR;
			endcase
		end
		next_s.arready = !next_s.rvalid;
		// --------------------------------------------------------
		// commands toward the codec
		// --------------------------------------------------------
		// (RULE_01) hold the command until taken
		if (s.out_valid && cmd_ready) begin
			next_s.out_valid = 1'b0;
		end
		if (pop) begin
			next_s.out_valid = 1'b1;
			next_s.out_word  = fifo_out_data;
		end
		// --------------------------------------------------------
		// status returned for a read
		// --------------------------------------------------------
		// (RULE_02) overwrite data with status
		if (apply) begin
			next_s.cap_pending  = 1'b0;
			next_s.read_pending = 1'b0;
			next_s.cmd_data_low = s.cap_data[7:0];
			next_s.cmd_address[6:0] = s.cap_addr;
			// (RULE_05) high byte kept in narrow modes
			if (ac97) begin
				next_s.cmd_data_high = s.cap_data[15:8];
			end
		end
		// (RULE_17) a fresh read wins over the clear
		if (push && s.cmd_address[CMD_RW_BIT]) begin
			next_s.read_pending = 1'b1;
		end
		// (RULE_19) only a fully received slot
		if (status_valid && s.read_pending) begin
			next_s.cap_pending = 1'b1;
			next_s.cap_data    = status_data;
			next_s.cap_addr    = status_addr;
		end
		// --------------------------------------------------------
		// ready flags and outgoing frame tags
		// --------------------------------------------------------
		// (RULE_10) primary ready per frame
		if (frame_start && ac97) begin
			next_s.slot_valid_high[PRI_READY_BIT] = primary_slot0_bit15;
			// (RULE_11) secondary ready per frame
			// (RULE_12) absent secondary reads zero
			next_s.slot_valid_high[SEC_READY_BIT] =
				s.ctrl[CTRL_ATTACH] && secondary_slot0_bit15;
		end
		// (RULE_14) tags only in ac97 modes
		for (int i = 0; i < 5; i++) begin
			// (RULE_07) slots 3..7
			next_s.slots[i]     = ac97 && next_s.slot_valid_high[4-i];
			// (RULE_06) slots 8..12
			next_s.slots[i + 5] = ac97 && next_s.slot_valid_low[7-i];
		end
		// (RULE_09) frame tag
		next_s.frame_tag = ac97 && next_s.slot_valid_high[FRAME_TAG_BIT];
	end

	// (RULE_16) everything clears on reset
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s      <= '0;
			s.ctrl <= RST_CTRL;
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign s_axi_awready   = s.awready;
	assign s_axi_wready    = s.wready;
	assign s_axi_bresp     = s.bresp;
	assign s_axi_bvalid    = s.bvalid;
	assign s_axi_arready   = s.arready;
	assign s_axi_rdata     = s.rdata;
	assign s_axi_rresp     = s.rresp;
	assign s_axi_rvalid    = s.rvalid;
	assign cmd_valid       = s.out_valid;
	assign cmd_read        = s.out_word[25];
	assign cmd_secondary   = s.out_word[24];
	assign cmd_addr        = s.out_word[23:16];
	assign cmd_data        = s.out_word[15:0];
	assign slot_valid      = s.slots;
	assign frame_valid_tag = s.frame_tag;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence hi_write_s;
		do_write && s.w_lane0 && wsel == CPS_SEL_VHIGH && !frame_start;
	endsequence
	sequence frame_load_s;
		frame_start && ac97;
	endsequence

	reserved_low_a: assert property (s.slot_valid_low[2:0] == 3'h0) // (RULE_15)
		else $error("reserved valid-slot bits not zero");
	ready_ro_a: assert property (hi_write_s |=> // (RULE_13)
		$stable(s.slot_valid_high[6:5]))
		else $error("software changed a ready flag");
	mode_gate_a: assert property (!ac97 |-> ##1 (slot_valid == '0)) // (RULE_14)
		else $error("slot tags driven outside ac97 mode");
	frame_tag_a: assert property (frame_valid_tag == // (RULE_09)
		(s.slot_valid_high[FRAME_TAG_BIT] && $past(ac97)))
		else $error("frame tag mismatch");
	slot_map_a: assert property (ac97 && $stable(s.ctrl) |=> // (RULE_06)
		slot_valid[9] == s.slot_valid_low[3] && slot_valid[0] == s.slot_valid_high[4])
		else $error("slot tag mapping wrong");
	primary_load_a: assert property (frame_load_s |=> // (RULE_10)
		s.slot_valid_high[PRI_READY_BIT] == $past(primary_slot0_bit15))
		else $error("primary ready not loaded");
	secondary_gate_a: assert property (frame_load_s and !s.ctrl[CTRL_ATTACH] |=> // (RULE_12)
		!s.slot_valid_high[SEC_READY_BIT])
		else $error("secondary ready set with no secondary codec");
	cmd_hold_a: assert property (cmd_valid && !cmd_ready |=> // (RULE_01)
		cmd_valid && $stable(s.out_word))
		else $error("command dropped before taken");
	read_update_a: assert property (apply |=> // (RULE_02)
		s.cmd_data_low == $past(s.cap_data[7:0]))
		else $error("status data not written back");
	narrow_high_a: assert property (apply && !ac97 && !data_wr |=> // (RULE_05)
		$stable(s.cmd_data_high))
		else $error("high data touched in narrow mode");
	defer_write_a: assert property (s.cap_pending && data_wr |=> s.cap_pending) // (RULE_19)
		else $error("status applied during software write");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response withdrawn");
endmodule : cps_codec_port
`default_nettype wire

// [sim/cps_codec_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// codec side: frames, ready tags, command sink, status replies
// ------------------------------------------------------------
module cps_codec_model (
	input  wire logic        clk_sys,
	input  wire logic        stall,
	input  wire logic        pri_level,
	input  wire logic        sec_level,
	output logic             frame_start,
	output logic             primary_slot0_bit15,
	output logic             secondary_slot0_bit15,
	output logic             status_valid,
	output logic [6:0]       status_addr,
	output logic [15:0]      status_data,
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic        cmd_read,
	input  wire logic        cmd_secondary,
	input  wire logic [7:0]  cmd_addr,
	input  wire logic [15:0] cmd_data
);
	logic [25:0] got [$];
	int          fcnt   = 0;
	int          wait_n = 0;
	logic [22:0] pend   = 23'h0;
	initial begin
		frame_start = 1'b0;
		primary_slot0_bit15 = 1'b0;
		secondary_slot0_bit15 = 1'b0;
		status_valid = 1'b0;
		status_addr = 7'h00;
		status_data = 16'h0000;
		cmd_ready = 1'b0;
	end
	always @(posedge clk_sys) begin
		fcnt <= (fcnt == 39) ? 0 : fcnt + 1;
		frame_start <= (fcnt == 39);
		// slot 0 tag, toggles between frames so stale use shows
		primary_slot0_bit15 <= (fcnt == 39) ? pri_level : ~primary_slot0_bit15;
		secondary_slot0_bit15 <= (fcnt == 39) ? sec_level : ~secondary_slot0_bit15;
		cmd_ready <= ~stall;
		// status lines carry junk outside the reply cycle
		status_valid <= (wait_n == 1);
		status_addr <= (wait_n == 1) ? pend[22:16] : ~status_addr;
		status_data <= (wait_n == 1) ? pend[15:0] : ~status_data;
		if (wait_n > 0) begin
			wait_n <= wait_n - 1;
		end
		if (cmd_valid && cmd_ready) begin
			got.push_back({cmd_read, cmd_secondary, cmd_addr, cmd_data});
			if (cmd_read) begin
				pend <= {cmd_addr[6:0] ^ 7'h11, cmd_data ^ 16'h5a3c};
				wait_n <= 5;
			end
		end
	end
endmodule : cps_codec_model
`default_nettype wire

// [sim/cps_codec_port_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module cps_codec_port_tb;
	import cps_pkg::*;
	logic                  clk_sys = 1'b0;
	logic                  rst = 1'b1;
	logic [AW-1:0]         s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0]           s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]            s_axi_wstrb = '0;
	logic [1:0]            s_axi_bresp, s_axi_rresp;
	logic                  s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic                  s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic                  frame_start, primary_slot0_bit15, secondary_slot0_bit15, status_valid;
	logic [6:0]            status_addr;
	logic [15:0]           status_data, cmd_data;
	logic                  cmd_valid, cmd_ready, cmd_read, cmd_secondary, frame_valid_tag;
	logic [7:0]            cmd_addr;
	logic [SLOT_COUNT-1:0] slot_valid;
	logic                  stall = 1'b0, pri_level = 1'b0, sec_level = 1'b0;
	int                    num_errors = 0, check_count = 0, i, k, n;
	logic [31:0]           seed, d;
	logic [1:0]            r;
	logic [7:0]            m [5];
	logic [7:0]            ctl;
	logic [25:0]           e;
	logic [25:0]           expq [$];
	logic                  full;
	logic [15:0]           ix [5] = '{IDX_VALID_HIGH, IDX_VALID_LOW, IDX_DATA_HIGH, IDX_DATA_LOW,
		IDX_CMD_ADDR};

	cps_codec_port u_cps_codec_port (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .frame_start,
		.primary_slot0_bit15, .secondary_slot0_bit15, .status_valid, .status_addr, .status_data,
		.cmd_valid, .cmd_ready, .cmd_read, .cmd_secondary, .cmd_addr, .cmd_data, .slot_valid,
		.frame_valid_tag);
	cps_codec_model u_cps_codec_model (.clk_sys, .stall, .pri_level, .sec_level, .frame_start,
		.primary_slot0_bit15, .secondary_slot0_bit15, .status_valid, .status_addr, .status_data,
		.cmd_valid, .cmd_ready, .cmd_read, .cmd_secondary, .cmd_addr, .cmd_data);

	always #50 clk_sys = ~clk_sys;

	// ------------------------------------------------------------
	// checking and bus tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic results();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results
	function automatic logic [AW-1:0] ba(input logic [15:0] idx);
		return AW'({idx, 2'b00});
	endfunction : ba
	task automatic wr(input logic [15:0] idx, input logic [7:0] v, input logic [3:0] st,
		output logic [1:0] resp);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge clk_sys);
		s_axi_awaddr <= ba(idx);
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {24'h0, v};
		s_axi_wstrb <= st;
		s_axi_wvalid <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge clk_sys);
			if (s_axi_awready === 1'b1) aw_done = 1'b1;
			if (s_axi_wready === 1'b1) w_done = 1'b1;
			if (aw_done) s_axi_awvalid <= 1'b0;
			if (w_done) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b1;
		do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] idx, output logic [31:0] v, output logic [1:0] resp);
		@(posedge clk_sys);
		s_axi_araddr <= ba(idx);
		s_axi_arvalid <= 1'b1;
		do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic w(input logic [15:0] idx, input logic [7:0] v);
		logic [1:0] rr;
		wr(idx, v, 4'h1, rr);
		check(32'(rr), 32'(RESP_OKAY));
	endtask : w
	task automatic rc(input logic [15:0] idx, input logic [7:0] exp);
		logic [31:0] v;
		logic [1:0]  rr;
		rd(idx, v, rr);
		check(v, 32'(exp));
		check(32'(rr), 32'(RESP_OKAY));
	endtask : rc
	// model write: reserved and ready bits never stick
	task automatic wm(input int j, input logic [7:0] v);
		m[j] = v & ((j == 0) ? VALID_HIGH_SW : (j == 1) ? VALID_LOW_MASK : 8'hff);
		w(ix[j], v);
	endtask : wm
	task automatic start_cmd();
		expq.push_back({m[4][7], ctl[4:3] != 2'b00, m[4], ctl[1] ? m[2] : 8'h00, m[3]});
		w(IDX_CTRL, ctl | 8'h80);
	endtask : start_cmd
	function automatic logic [9:0] sv(input logic [7:0] h, input logic [7:0] l);
		return {l[3], l[4], l[5], l[6], l[7], h[0], h[1], h[2], h[3], h[4]};
	endfunction : sv

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		seed = 32'h52f7;
		for (i = 0; i < 5; i++) m[i] = 8'h00;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		for (i = 0; i < 5; i++) rc(ix[i], 8'h00);
		rd(16'h0100, d, r);
		check(d, 32'h0);
		check(32'(r), 32'(RESP_SLVERR));
		wr(16'h0100, 8'hff, 4'h1, r);
		check(32'(r), 32'(RESP_SLVERR));
		wr(IDX_DATA_LOW, 8'h77, 4'h0, r);
		check(32'(r), 32'(RESP_OKAY));
		rc(IDX_DATA_LOW, 8'h00);
		// slot tags in every mode, reserved and read-only bits
		for (i = 0; i < 6; i++) begin
			ctl = {6'h0, ~i[2], i[0]};
			w(IDX_CTRL, ctl);
			wm(0, 8'($random(seed)));
			wm(1, 8'($random(seed)));
			rc(ix[0], m[0]);
			rc(ix[1], m[1]);
			repeat (2) @(posedge clk_sys);
			check(32'(slot_valid), 32'(ctl[1] ? sv(m[0], m[1]) : 10'h0));
			check(32'(frame_valid_tag), 32'(ctl[1] & m[0][7]));
		end
		// ready flags, secondary gated by attach
		for (i = 0; i < 4; i++) begin
			ctl = {5'h0, i[1], 2'b10};
			pri_level <= i[0];
			sec_level <= i[0] ^ i[1];
			w(IDX_CTRL, ctl);
			repeat (90) @(posedge clk_sys);
			rc(ix[0], m[0] | {1'b0, i[0], i[1] & ~i[0], 5'h0});
		end
		// commands in all modes, both directions, random codec id
		for (i = 0; i < 8; i++) begin
			ctl = {3'h0, 2'($random(seed)), 1'b1, i[2:1]};
			w(IDX_CTRL, ctl);
			wm(2, 8'($random(seed)));
			wm(3, 8'($random(seed)));
			wm(4, {i[0], 7'($random(seed))});
			n = u_cps_codec_model.got.size();
			start_cmd();
			for (k = 0; k < 50 && u_cps_codec_model.got.size() == n; k++) @(posedge clk_sys);
			e = expq.pop_front();
			check(32'(u_cps_codec_model.got[n]), 32'(e));
			if (i[0]) begin
				repeat (15) @(posedge clk_sys);
				m[3] = e[7:0] ^ 8'h3c;
				if (ctl[1]) m[2] = e[15:8] ^ 8'h5a;
				m[4] = {m[4][7], e[22:16] ^ 7'h11};
				rc(ix[3], m[3]);
				rc(ix[2], m[2]);
				rc(ix[4], m[4]);
			end
		end
		// fill the command buffer with the codec stalled, then drain
		stall <= 1'b1;
		ctl = 8'h00;
		w(IDX_CTRL, ctl);
		n = u_cps_codec_model.got.size();
		full = 1'b0;
		for (k = 0; k < 20 && full !== 1'b1; k++) begin
			wm(3, 8'(k));
			start_cmd();
			rd(IDX_STATUS, d, r);
			full = d[2];
		end
		check(32'(k >= FIFO_DEPTH && k <= FIFO_DEPTH + 1), 32'h1);
		w(IDX_CTRL, 8'h80);
		stall <= 1'b0;
		repeat (100) @(posedge clk_sys);
		check(32'(u_cps_codec_model.got.size()), 32'(n + k));
		for (i = 0; i < k; i++) check(32'(u_cps_codec_model.got[n + i]), 32'(expq[i]));
		results();
	end

	initial begin
		#1000000;
		num_errors++;
		results();
	end
endmodule : cps_codec_port_tb
`default_nettype wire
